// ---- common/mix_cfg.svh ----
/*
 * Fixed constants of the two-source pixel mixer output stage: weight
 * saturation, rounding offsets and masks, scaling shift, clamp limits.
 * Assumes it is included by bare name by the output stage design file.
 */
`ifndef MIX_CFG_SVH
`define MIX_CFG_SVH

// weight of exactly one: one integer bit, eleven fraction bits
`define MIX_WEIGHT_ONE 13'h0800
// products carry eleven fraction bits; the doubling leaves ten to drop
`define MIX_SCALE_SHIFT 4'ha
// format level that selects two's complement pixels
`define MIX_TC_SIGNED 1'b0

// half of one output lsb, expressed in accumulator units
`define MIX_HALF_8 26'h000_4000
`define MIX_HALF_10 26'h000_1000
`define MIX_HALF_12 26'h000_0400
`define MIX_HALF_13 26'h000_0200

// bits kept after rounding; the rest are forced to zero
`define MIX_KEEP_8 13'h1fe0
`define MIX_KEEP_10 13'h1ff8
`define MIX_KEEP_12 13'h1ffe
`define MIX_KEEP_13 13'h1fff

// clamp limits of the 13-bit result
`define MIX_SIGNED_MAX 13'h0fff
`define MIX_SIGNED_MIN 13'h1000
`define MIX_UNSIGNED_MAX 13'h1fff
`define MIX_UNSIGNED_MIN 13'h0000

`endif

// ---- common/mix_pkg.sv ----
/*
 * Types shared by the pixel mixer output stage.
 * Assumes mix_cfg.svh is reachable on the include path.
 */
`default_nettype none

package mix_pkg;

    // rounding width selected per pixel pair
    typedef enum logic [1:0] {
        RND_W8 = 2'b00,
        RND_W10 = 2'b01,
        RND_W12 = 2'b10,
        RND_W13 = 2'b11
    } round_width_t;

    typedef logic [11:0] pixel_t;
    typedef logic signed [12:0] operand_t;
    typedef logic signed [25:0] acc_t;
    typedef logic [12:0] result_t;

endpackage : mix_pkg

`default_nettype wire

// ---- hw/mix_skid_buffer.sv ----
/*
 * Small register FIFO with valid/ready on both sides.
 * Assumes one clock, synchronous active-high reset, DEPTH of two or more.
 */
`timescale 1ns/1ns
`default_nettype none

module mix_skid_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [PW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [CW-1:0] count_q, count_d;
    logic push, pop;

    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
        next_ptr = (p == LAST) ? '0 : p + PW'(1);
    endfunction : next_ptr

    assign in_ready = (count_q != FULL);
    assign out_valid = (count_q != '0);
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        mem_d = mem_q;
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        count_d = count_q;
        if (push) begin
            mem_d[wr_ptr_q] = in_data;
            wr_ptr_d = next_ptr(wr_ptr_q);
        end
        if (pop) begin
            rd_ptr_d = next_ptr(rd_ptr_q);
        end
        // simultaneous push and pop keeps the fill level
        if (push && !pop) begin
            count_d = count_q + CW'(1);
        end else if (pop && !push) begin
            count_d = count_q - CW'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
            mem_q <= mem_d;
        end
    end

endmodule : mix_skid_buffer

`default_nettype wire

// ---- hw/video_mix_output_stage.sv ----
/*
 * Two-source pixel mixer datapath: doubled weighted sum of two 12-bit
 * pixels, rounding, clamping and a registered 13-bit result with an
 * asynchronous drive enable.
 * Assumes one 100 MHz clock, synchronous inputs, a synchronous active-high
 * reset, and a downstream reader that may stall through out_ready.
 */
`timescale 1ns/1ns
`default_nettype none

`include "mix_cfg.svh"

// Overview of operation
// - result is twice weighted sum of pixels
// - sampled format level decides signed or unsigned
// - sampled round width travels with its pixels
// - result held in output register while stalled
// - low drive control drives bus, high releases
// - level 0 signed, 1 unsigned, both pixels
// - add half lsb, zero lower bits; 8/10/12/13
// - six register stages, controls delayed alike
// - 13-bit result from 12-bit inputs
module video_mix_output_stage #(
    parameter int BUF_DEPTH = 2
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [11:0] pixel_a,
    input wire logic [11:0] pixel_b,
    input wire logic [11:0] weight,
    input wire logic twos_comp_n,
    input wire logic [1:0] round_sel,
    output logic out_valid,
    input wire logic out_ready,
    input wire logic out_drive_n,
    output logic [12:0] mixed_out,
    output logic mixed_out_oe
);

    localparam int IN_W = 12 + 12 + 12 + 1 + 2;

    // buffered input word
    logic buf_valid;
    logic [IN_W-1:0] buf_data;
    logic adv;

    // stage 1: sampled inputs and format controls
    logic s1_v_q, s1_v_d;
    mix_pkg::pixel_t s1_a_q, s1_a_d, s1_b_q, s1_b_d, s1_w_q, s1_w_d;
    logic s1_tc_q, s1_tc_d;
    mix_pkg::round_width_t s1_rnd_q, s1_rnd_d;
    // stage 2: extended operands, saturated weight and its complement
    logic s2_v_q, s2_v_d;
    mix_pkg::operand_t s2_a_q, s2_a_d, s2_b_q, s2_b_d, s2_w_q, s2_w_d, s2_wc_q, s2_wc_d;
    logic s2_tc_q, s2_tc_d;
    mix_pkg::round_width_t s2_rnd_q, s2_rnd_d;
    // stage 3: products
    logic s3_v_q, s3_v_d;
    mix_pkg::acc_t s3_pa_q, s3_pa_d, s3_pb_q, s3_pb_d;
    logic s3_tc_q, s3_tc_d;
    mix_pkg::round_width_t s3_rnd_q, s3_rnd_d;
    // stage 4: weighted sum
    logic s4_v_q, s4_v_d;
    mix_pkg::acc_t s4_sum_q, s4_sum_d;
    logic s4_tc_q, s4_tc_d;
    mix_pkg::round_width_t s4_rnd_q, s4_rnd_d;
    // stage 5: rounded and scaled
    logic s5_v_q, s5_v_d;
    logic signed [15:0] s5_val_q, s5_val_d;
    logic s5_tc_q, s5_tc_d;
    mix_pkg::round_width_t s5_rnd_q, s5_rnd_d;
    // stage 6: output register
    logic out_v_q, out_v_d;
    mix_pkg::result_t out_q, out_d;

    mix_pkg::acc_t rnd_acc;

    function automatic mix_pkg::operand_t ext_pixel(input mix_pkg::pixel_t p, input logic tc);
        ext_pixel = (tc == `MIX_TC_SIGNED) ? {p[11], p} : {1'b0, p};
    endfunction : ext_pixel

    // weights above one are clamped to exactly one
    function automatic mix_pkg::operand_t sat_weight(input mix_pkg::pixel_t w);
        sat_weight = ({1'b0, w} > `MIX_WEIGHT_ONE) ? `MIX_WEIGHT_ONE : {1'b0, w};
    endfunction : sat_weight

    function automatic mix_pkg::acc_t round_half(input mix_pkg::round_width_t r);
        case (r)
            mix_pkg::RND_W8: round_half = `MIX_HALF_8;
            mix_pkg::RND_W10: round_half = `MIX_HALF_10;
            mix_pkg::RND_W12: round_half = `MIX_HALF_12;
            mix_pkg::RND_W13: round_half = `MIX_HALF_13;
            default: round_half = `MIX_HALF_13;
        endcase
    endfunction : round_half

    function automatic mix_pkg::result_t keep_mask(input mix_pkg::round_width_t r);
        case (r)
            mix_pkg::RND_W8: keep_mask = `MIX_KEEP_8;
            mix_pkg::RND_W10: keep_mask = `MIX_KEEP_10;
            mix_pkg::RND_W12: keep_mask = `MIX_KEEP_12;
            mix_pkg::RND_W13: keep_mask = `MIX_KEEP_13;
            default: keep_mask = `MIX_KEEP_13;
        endcase
    endfunction : keep_mask

    // rounding can carry past the top; saturate instead of wrapping
    function automatic mix_pkg::result_t clamp(input logic signed [15:0] v, input logic tc);
        if (tc == `MIX_TC_SIGNED) begin
            if (v[15:12] == 4'h0 || v[15:12] == 4'hf) begin
                clamp = v[12:0];
            end else begin
                clamp = v[15] ? `MIX_SIGNED_MIN : `MIX_SIGNED_MAX;
            end
        end else begin
            if (v[15]) begin
                clamp = `MIX_UNSIGNED_MIN;
            end else if (v[15:13] != 3'h0) begin
                clamp = `MIX_UNSIGNED_MAX;
            end else begin
                clamp = v[12:0];
            end
        end
    endfunction : clamp

    // a stalled reader freezes every stage while a valid result waits in the output register, so no word is lost
    assign adv = !(out_v_q && !out_ready);

    mix_skid_buffer #(
        .WIDTH(IN_W),
        .DEPTH(BUF_DEPTH)
    ) u_in_buf (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data({pixel_a, pixel_b, weight, twos_comp_n, round_sel}),
        .out_valid(buf_valid),
        .out_ready(adv),
        .out_data(buf_data)
    );

    always_comb begin
        s1_v_d = s1_v_q;
        s1_a_d = s1_a_q;
        s1_b_d = s1_b_q;
        s1_w_d = s1_w_q;
        s1_tc_d = s1_tc_q;
        s1_rnd_d = s1_rnd_q;
        s2_v_d = s2_v_q;
        s2_a_d = s2_a_q;
        s2_b_d = s2_b_q;
        s2_w_d = s2_w_q;
        s2_wc_d = s2_wc_q;
        s2_tc_d = s2_tc_q;
        s2_rnd_d = s2_rnd_q;
        s3_v_d = s3_v_q;
        s3_pa_d = s3_pa_q;
        s3_pb_d = s3_pb_q;
        s3_tc_d = s3_tc_q;
        s3_rnd_d = s3_rnd_q;
        s4_v_d = s4_v_q;
        s4_sum_d = s4_sum_q;
        s4_tc_d = s4_tc_q;
        s4_rnd_d = s4_rnd_q;
        s5_v_d = s5_v_q;
        s5_val_d = s5_val_q;
        s5_tc_d = s5_tc_q;
        s5_rnd_d = s5_rnd_q;
        out_v_d = out_v_q;
        out_d = out_q;
        rnd_acc = s4_sum_q + round_half(s4_rnd_q);
        if (adv) begin
            // controls are sampled with their own pixels and ride along
            s1_v_d = buf_valid;
            {s1_a_d, s1_b_d, s1_w_d} = buf_data[IN_W-1:3];
            s1_tc_d = buf_data[2];
            s1_rnd_d = mix_pkg::round_width_t'(buf_data[1:0]);
            s2_v_d = s1_v_q;
            s2_a_d = ext_pixel(s1_a_q, s1_tc_q);
            s2_b_d = ext_pixel(s1_b_q, s1_tc_q);
            s2_w_d = sat_weight(s1_w_q);
            s2_wc_d = `MIX_WEIGHT_ONE - sat_weight(s1_w_q);
            s2_tc_d = s1_tc_q;
            s2_rnd_d = s1_rnd_q;
            s3_v_d = s2_v_q;
            // widen before the product so no operand is padded implicitly
            s3_pa_d = mix_pkg::acc_t'(s2_a_q) * mix_pkg::acc_t'(s2_w_q);
            s3_pb_d = mix_pkg::acc_t'(s2_b_q) * mix_pkg::acc_t'(s2_wc_q);
            s3_tc_d = s2_tc_q;
            s3_rnd_d = s2_rnd_q;
            s4_v_d = s3_v_q;
            s4_sum_d = s3_pa_q + s3_pb_q;
            s4_tc_d = s3_tc_q;
            s4_rnd_d = s3_rnd_q;
            s5_v_d = s4_v_q;
            // doubling folded into a ten-bit shift of eleven fraction bits
            s5_val_d = 16'(rnd_acc >>> `MIX_SCALE_SHIFT);
            s5_tc_d = s4_tc_q;
            s5_rnd_d = s4_rnd_q;
            out_v_d = s5_v_q;
            out_d = clamp(s5_val_q, s5_tc_q) & keep_mask(s5_rnd_q);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s1_v_q <= 1'b0;
            s1_a_q <= '0;
            s1_b_q <= '0;
            s1_w_q <= '0;
            s1_tc_q <= 1'b0;
            s1_rnd_q <= mix_pkg::RND_W13;
            s2_v_q <= 1'b0;
            s2_a_q <= '0;
            s2_b_q <= '0;
            s2_w_q <= '0;
            s2_wc_q <= '0;
            s2_tc_q <= 1'b0;
            s2_rnd_q <= mix_pkg::RND_W13;
            s3_v_q <= 1'b0;
            s3_pa_q <= '0;
            s3_pb_q <= '0;
            s3_tc_q <= 1'b0;
            s3_rnd_q <= mix_pkg::RND_W13;
            s4_v_q <= 1'b0;
            s4_sum_q <= '0;
            s4_tc_q <= 1'b0;
            s4_rnd_q <= mix_pkg::RND_W13;
            s5_v_q <= 1'b0;
            s5_val_q <= '0;
            s5_tc_q <= 1'b0;
            s5_rnd_q <= mix_pkg::RND_W13;
            out_v_q <= 1'b0;
            out_q <= '0;
        end else begin
            s1_v_q <= s1_v_d;
            s1_a_q <= s1_a_d;
            s1_b_q <= s1_b_d;
            s1_w_q <= s1_w_d;
            s1_tc_q <= s1_tc_d;
            s1_rnd_q <= s1_rnd_d;
            s2_v_q <= s2_v_d;
            s2_a_q <= s2_a_d;
            s2_b_q <= s2_b_d;
            s2_w_q <= s2_w_d;
            s2_wc_q <= s2_wc_d;
            s2_tc_q <= s2_tc_d;
            s2_rnd_q <= s2_rnd_d;
            s3_v_q <= s3_v_d;
            s3_pa_q <= s3_pa_d;
            s3_pb_q <= s3_pb_d;
            s3_tc_q <= s3_tc_d;
            s3_rnd_q <= s3_rnd_d;
            s4_v_q <= s4_v_d;
            s4_sum_q <= s4_sum_d;
            s4_tc_q <= s4_tc_d;
            s4_rnd_q <= s4_rnd_d;
            s5_v_q <= s5_v_d;
            s5_val_q <= s5_val_d;
            s5_tc_q <= s5_tc_d;
            s5_rnd_q <= s5_rnd_d;
            out_v_q <= out_v_d;
            out_q <= out_d;
        end
    end

    assign out_valid = out_v_q;
    // value is always presented; the enable alone decides whether it reaches the wire
    assign mixed_out = out_q;
    assign mixed_out_oe = !out_drive_n;

endmodule : video_mix_output_stage

`default_nettype wire

// ---- verification/mix_monitor.sv ----
/* port assertions for the mixer output stage.
   assumes binding into video_mix_output_stage, one clock. */
`timescale 1ns/1ns
`default_nettype none
module mix_monitor #(
    parameter int BUF_DEPTH = 2
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic [1:0] round_sel,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic out_drive_n,
    input wire logic [12:0] mixed_out,
    input wire logic mixed_out_oe
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    // two idle cycles empty the buffer, so latency is exact
    sequence s_fresh(logic [1:0] rs);
        (!in_valid && out_ready) [*2] ##1 (in_valid && in_ready && out_ready && round_sel == rs) ##1 out_ready [*6];
    endsequence
    property p_drive;
        mixed_out_oe == !out_drive_n;
    endproperty
    a_drive: assert property (p_drive) else $error("drive enable wrong");
    property p_hold;
        out_valid && !out_ready |=> out_valid && $stable(mixed_out);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled result moved");
    property p_latency;
        s_fresh(round_sel) |=> out_valid;
    endproperty
    a_latency: assert property (p_latency) else $error("result late");
    property p_round8;
        s_fresh(2'h0) |=> mixed_out[4:0] == 5'h00;
    endproperty
    a_round8: assert property (p_round8) else $error("low bits not cleared");
    property p_round10;
        s_fresh(2'h1) |=> mixed_out[2:0] == 3'h0;
    endproperty
    a_round10: assert property (p_round10) else $error("low bits not cleared");
    property p_round12;
        s_fresh(2'h2) |=> mixed_out[0] == 1'b0;
    endproperty
    a_round12: assert property (p_round12) else $error("low bit not cleared");
    property p_drive_keep;
        out_valid && !out_ready && $changed(out_drive_n) |=> $stable(mixed_out);
    endproperty
    a_drive_keep: assert property (p_drive_keep) else $error("enable moved result");
    property p_full;
        (in_valid && out_valid && !out_ready) [*3] |-> !in_ready;
    endproperty
    a_full: assert property (p_full) else $error("buffer overfilled");
endmodule : mix_monitor
bind video_mix_output_stage mix_monitor #(.BUF_DEPTH(BUF_DEPTH)) u_mix_monitor (.sys_clk, .reset, .in_valid,
    .in_ready, .round_sel, .out_valid, .out_ready, .out_drive_n, .mixed_out, .mixed_out_oe);
`default_nettype wire

// ---- verification/mix_sink_model.sv ----
/* downstream reader: takes results, stalls on request.
   assumes the bench reads got_q by hierarchy. */
`timescale 1ns/1ns
`default_nettype none
module mix_sink_model (
    input wire logic sys_clk,
    input wire logic stall,
    input wire logic out_valid,
    input wire logic [12:0] mixed_out,
    input wire logic mixed_out_oe,
    output logic out_ready
);
    logic [12:0] got_q[$];
    logic [12:0] bus;
    // a released bus floats; show the inverse so a read of it is caught
    assign bus = mixed_out_oe ? mixed_out : ~mixed_out;
    assign out_ready = !stall;
    always @(posedge sys_clk) begin
        if (out_valid && out_ready) begin
            got_q.push_back(bus);
        end
    end
endmodule : mix_sink_model
`default_nettype wire

// ---- verification/testbench.sv ----
/* self-checking bench for the mixer output stage.
   assumes the sink model and the bound monitor. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic in_valid = 1'b0;
    logic [11:0] pixel_a = 12'h000;
    logic [11:0] pixel_b = 12'h000;
    logic [11:0] weight = 12'h000;
    logic twos_comp_n = 1'b0;
    logic [1:0] round_sel = 2'h0;
    logic out_drive_n = 1'b0;
    logic stall = 1'b0;
    logic in_ready, out_valid, out_ready, mixed_out_oe;
    logic [12:0] mixed_out;
    int failures = 0;
    int checks = 0;
    logic [12:0] exp_q[$];
    video_mix_output_stage #(.BUF_DEPTH(2)) u_video_mix_output_stage (.sys_clk, .reset, .in_valid, .in_ready,
        .pixel_a, .pixel_b, .weight, .twos_comp_n, .round_sel, .out_valid, .out_ready, .out_drive_n,
        .mixed_out, .mixed_out_oe);
    mix_sink_model u_mix_sink_model (.sys_clk, .stall, .out_valid, .mixed_out, .mixed_out_oe, .out_ready);
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic check(input string what, input logic [12:0] seen, input logic [12:0] want);
        checks++;
        if (seen !== want) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask : check
    function automatic logic [12:0] mix(input logic [11:0] a, b, w, input logic tc, input logic [1:0] rs);
        int sa, sb, ww, v, d;
        sa = tc ? int'(a) : int'($signed(a));
        sb = tc ? int'(b) : int'($signed(b));
        ww = (w > 12'h800) ? 2048 : int'(w);
        d = (rs == 2'h0) ? 5 : (rs == 2'h1) ? 3 : (rs == 2'h2) ? 1 : 0;
        v = (sa * ww + sb * (2048 - ww) + (512 << d)) >>> 10;
        // saturate, not wrap
        if (tc) v = (v < 0) ? 0 : (v > 8191) ? 8191 : v;
        else v = (v < -4096) ? -4096 : (v > 4095) ? 4095 : v;
        return 13'(v >>> d <<< d);
    endfunction : mix
    task automatic send(input logic [11:0] a, b, w, input logic tc, input logic [1:0] rs);
        exp_q.push_back(mix(a, b, w, tc, rs));
        in_valid <= 1'b1;
        pixel_a <= a;
        pixel_b <= b;
        weight <= w;
        twos_comp_n <= tc;
        round_sel <= rs;
        do @(posedge sys_clk); while (in_ready !== 1'b1);
    endtask : send
    task automatic drain();
        for (int i = 0; i < 300 && u_mix_sink_model.got_q.size() < exp_q.size(); i++) @(posedge sys_clk);
        check("count", 13'(u_mix_sink_model.got_q.size()), 13'(exp_q.size()));
        while (exp_q.size() > 0 && u_mix_sink_model.got_q.size() > 0)
            check("mixed_out", u_mix_sink_model.got_q.pop_front(), exp_q.pop_front());
        exp_q.delete();
        u_mix_sink_model.got_q.delete();
    endtask : drain
    task automatic t_modes();
        // controls change every third word, back to back
        for (int m = 0; m < 8; m++) begin
            send(12'h7ff, 12'h800, 12'h800, m[2], 2'(m));
            send(12'h123, 12'h9ab, 12'h400, m[2], 2'(m));
            send(12'hfff, 12'h001, 12'hfff, m[2], 2'(m));
        end
        in_valid <= 1'b0;
        drain();
    endtask : t_modes
    task automatic t_latency();
        for (int r = 0; r < 3; r++) begin
            in_valid <= 1'b0;
            repeat (3) @(posedge sys_clk);
            send(12'h345, 12'h0ab, 12'h600, 1'b1, 2'(r));
            in_valid <= 1'b0;
            repeat (5) @(posedge sys_clk);
            #1 check("early", {12'h000, out_valid}, 13'h0000);
            @(posedge sys_clk);
            #1 check("valid", {12'h000, out_valid}, 13'h0001);
            @(posedge sys_clk);
        end
        drain();
    endtask : t_latency
    task automatic t_stall();
        stall <= 1'b1;
        fork
            begin
                repeat (30) @(posedge sys_clk);
                check("in_ready", {12'h000, in_ready}, 13'h0000);
                stall <= 1'b0;
            end
            for (int i = 1; i < 13; i++) send(12'(i * 301), 12'(i * 77), 12'(i * 180), i[0], 2'(i));
        join
        in_valid <= 1'b0;
        drain();
    endtask : t_stall
    task automatic t_drive();
        stall <= 1'b1;
        send(12'h9c4, 12'h1f0, 12'h2aa, 1'b0, 2'h3);
        in_valid <= 1'b0;
        for (int i = 0; i < 20 && out_valid !== 1'b1; i++) @(posedge sys_clk);
        for (int k = 0; k < 3; k++) begin
            out_drive_n <= k[0];
            // off-edge look: a registered enable would lag
            #1 check("oe", {12'h000, mixed_out_oe}, {12'h000, !k[0]});
            check("held", mixed_out, exp_q[0]);
            @(posedge sys_clk);
        end
        stall <= 1'b0;
        drain();
    endtask : t_drive
    task automatic end_sim();
        if (failures == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    initial begin
        #20000;
        failures++;
        end_sim();
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        t_modes();
        t_latency();
        t_stall();
        t_drive();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
